// ---- rtl/ubt_pkg.sv ----
// Shared constants and types for the bulk-in timing and configuration block
package ubt_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CFG0 = 8'h80;
    localparam logic [7:0] OFS_DETACH = 8'h88;
    localparam logic [7:0] OFS_BURST = 8'h90;
    localparam logic [7:0] OFS_DELAY = 8'h94;
    localparam logic [7:0] OFS_STATUS = 8'h9c;

    // Field positions in usb_config_zero
    localparam int CFG0_SCALE_LSB = 0;
    localparam int CFG0_TXEQ_BIT = 4;
    localparam int CFG0_BURST_EN_BIT = 5;

    // Values after reset
    localparam logic [15:0] SS_DETACH_HW = 16'h001e;
    localparam logic [15:0] HIGHSPEED_DETACH_MS_HW = 16'h000a;
    localparam logic [7:0] BURST_RST = 8'h00;
    localparam logic [15:0] DELAY_RST = 16'h0800;
    localparam logic [1:0] SCALE_RST = 2'h0;
    localparam logic TXEQ_EN_RST = 1'b1;
    localparam logic BURST_EN_RST = 1'b0;

    // Clock and time units
    localparam int CLK_NS = 40;
    localparam logic [31:0] CLK_PS = 32'h00009c40;
    localparam logic [31:0] DELAY_UNIT_PS = 32'h0000411b;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;

    // Burst units and packet sizes, bytes
    localparam logic [19:0] UNIT_SS = 20'h00400;
    localparam logic [19:0] UNIT_HS = 20'h00200;
    localparam logic [19:0] UNIT_FS = 20'h00040;
    localparam logic [19:0] BURST_MIN_BYTES = 20'h00800;

    // SuperSpeed link timing, real and scaled
    localparam logic [16:0] TXEQ_REAL = 17'h10000;
    localparam logic [16:0] TXEQ_SCALED = 17'h00008;
    localparam logic [16:0] LFPS_POLL_REAL_NS = 17'h003e8;
    localparam logic [16:0] LFPS_POLL_SCALED_NS = 17'h00064;
    localparam logic [16:0] WARM_RX_REAL_US = 17'h13880;
    localparam logic [16:0] WARM_RX_SCALED_US = 17'h0001e;

    typedef enum logic [1:0] {
        SPD_FS = 2'b00,
        SPD_HS = 2'b01,
        SPD_SS = 2'b10
    } ubt_speed_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DELAY = 2'b01
    } ubt_tx_e;

    typedef struct packed {
        logic [1:0] scale;
        logic txeq_en;
        logic burst_en;
        logic [15:0] ss_det;
        logic [15:0] hs_det;
        logic [15:0] img_ss;
        logic [15:0] img_hs;
        logic [7:0] bulk_in_burst_limit;
        logic [15:0] delay;
        logic detached;
        logic [15:0] det_ms;
        logic [14:0] ms_cnt;
        ubt_tx_e tx;
        logic [19:0] byte_cnt;
        logic [31:0] wait_ps;
        logic pkt_full;
        logic pkt_short;
        logic [31:0] rdata;
        logic [16:0] txeq_cnt;
        logic [16:0] lfps_ns;
        logic [16:0] warm_us;
        logic hs_scale_timing;
        logic hs_scale_susp;
    } ubt_state_s;

endpackage : ubt_pkg

// ---- rtl/ubt_usb_bulk_in.sv ----
// Bulk-in timing, detach and burst configuration block with register port
// Contract
// - Scale field 0 real timing, 1 scales all but suspend/resume, 2 only those, 3 both.
// - Scale 1 in SuperSpeed gives 8 TxEq sequences, 100 ns LFPS polling, 30 us warm reset.
// - Scale 2 in SuperSpeed sends no TxEq sequences and overrides configuration bit 4.
// - Fields default from EEPROM image if present, else OTP, else hard values.
// - USB or lite reset restores fields to the last loaded image, or hard values.
// - Bits 31:16 hold SuperSpeed detach time in ms, default 0x1E, used after soft reset.
// - Bits 15:0 hold high/full-speed detach time in ms, default 0x0A.
// - Both detach fields survive a USB or lite reset while reset protection is set.
// - The transmitter ends a burst at the limit with a short or zero-length packet.
// - Eight-bit burst limit, reset 00h, in 1024, 512 or 64 byte units by speed.
// - The burst limit acts only while its enable bit in usb_config_zero is set.
// - The burst limit is off when it amounts to 2048 bytes or less.
// - A short or zero-length packet waits the delay in 16.667 ns units, reset 0800h.
`timescale 1ns/100ps
module ubt_usb_bulk_in
    import ubt_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
) (
    input wire logic clk_sys_i, // System clock, 25 MHz
    input wire logic reset_i, // Synchronous power-on reset
    input wire logic usb_reset_i, // USB bus reset pulse
    input wire logic lite_reset_i, // Lite reset pulse
    input wire logic rst_protect_i, // Reset protection level
    input wire logic img_load_i, // Configuration image load pulse
    input wire logic eeprom_present_i, // EEPROM image present
    input wire logic otp_configured_i, // OTP programmed
    input wire logic [15:0] eeprom_ss_det_i, // EEPROM SuperSpeed detach
    input wire logic [15:0] eeprom_hs_det_i, // EEPROM high-speed detach
    input wire logic [15:0] otp_ss_det_i, // OTP SuperSpeed detach
    input wire logic [15:0] otp_hs_det_i, // OTP high-speed detach
    input wire logic soft_reset_req_i, // Soft reset request pulse
    input wire logic [1:0] speed_i, // Link speed
    input wire logic in_token_i, // Bulk-in token pulse
    input wire logic data_full_i, // A full packet is queued
    input wire logic [7:0] addr_i, // Register byte address
    input wire logic [31:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [31:0] rdata_o, // Read data, cycle after strobe
    output logic detached_o, // Device detached from bus
    output logic pkt_full_o, // Full packet sent pulse
    output logic pkt_short_o, // Short or zero-length packet pulse
    output logic [16:0] txeq_count_o, // TxEq training sequences
    output logic [16:0] lfps_poll_ns_o, // LFPS polling burst, ns
    output logic [16:0] warm_rx_us_o, // Warm reset receive, us
    output logic hs_scale_timing_o, // HS/FS scaled general timing
    output logic hs_scale_susp_o // HS/FS scaled suspend/resume
);

    ubt_state_s st;
    ubt_state_s nxt_st;
    logic [19:0] limit_bytes;
    logic [19:0] mps;
    logic limit_on;
    logic ms_tick;
    logic rst_restore;

    always_comb begin
        case (speed_i)
            SPD_SS: begin
                limit_bytes = 20'(st.bulk_in_burst_limit) * UNIT_SS;
                mps = UNIT_SS;
            end
            SPD_HS: begin
                limit_bytes = 20'(st.bulk_in_burst_limit) * UNIT_HS;
                mps = UNIT_HS;
            end
            default: begin
                limit_bytes = 20'(st.bulk_in_burst_limit) * UNIT_FS;
                mps = UNIT_FS;
            end
        endcase
        limit_on = st.burst_en && (limit_bytes > BURST_MIN_BYTES);
    end

    assign ms_tick = (st.ms_cnt == 15'(MS_CYC - 1));
    // Protection gates only USB and lite resets; reset_i always applies
    assign rst_restore = (usb_reset_i || lite_reset_i) && !rst_protect_i;

    always_comb begin
        nxt_st = st;
        nxt_st.pkt_full = 1'b0;
        nxt_st.pkt_short = 1'b0;
        nxt_st.rdata = 32'h0;

        if (img_load_i) begin
            if (eeprom_present_i) begin
                nxt_st.img_ss = eeprom_ss_det_i;
                nxt_st.img_hs = eeprom_hs_det_i;
            end else if (otp_configured_i) begin
                nxt_st.img_ss = otp_ss_det_i;
                nxt_st.img_hs = otp_hs_det_i;
            end else begin
                nxt_st.img_ss = SS_DETACH_HW;
                nxt_st.img_hs = HIGHSPEED_DETACH_MS_HW;
            end
            nxt_st.ss_det = nxt_st.img_ss;
            nxt_st.hs_det = nxt_st.img_hs;
        end

        // Register writes
        if (wr_i) begin
            if (addr_i == OFS_CFG0) begin
                nxt_st.scale = wdata_i[CFG0_SCALE_LSB +: 2];
                nxt_st.txeq_en = wdata_i[CFG0_TXEQ_BIT];
                nxt_st.burst_en = wdata_i[CFG0_BURST_EN_BIT];
            end else if (addr_i == OFS_DETACH) begin
                nxt_st.ss_det = wdata_i[31:16];
                nxt_st.hs_det = wdata_i[15:0];
            end else if (addr_i == OFS_BURST) begin
                nxt_st.bulk_in_burst_limit = wdata_i[7:0];
            end else if (addr_i == OFS_DELAY) begin
                nxt_st.delay = wdata_i[15:0];
            end
        end

        // restore unless protected; reset beats a same-cycle write
        if (rst_restore) begin
            nxt_st.ss_det = st.img_ss;
            nxt_st.hs_det = st.img_hs;
        end

        // Register reads, unmapped reads as zero
        if (rd_i) begin
            if (addr_i == OFS_CFG0) begin
                nxt_st.rdata = {26'h0, st.burst_en, st.txeq_en, 2'h0, st.scale};
            end else if (addr_i == OFS_DETACH) begin
                nxt_st.rdata = {st.ss_det, st.hs_det};
            end else if (addr_i == OFS_BURST) begin
                nxt_st.rdata = {24'h0, st.bulk_in_burst_limit};
            end else if (addr_i == OFS_DELAY) begin
                nxt_st.rdata = {16'h0, st.delay};
            end else if (addr_i == OFS_STATUS) begin
                nxt_st.rdata = {9'h0, limit_on, st.tx, st.detached, st.byte_cnt[18:0]};
            end
        end

        // detach after soft reset, duration by speed
        if (soft_reset_req_i) begin
            nxt_st.detached = 1'b1;
            nxt_st.det_ms = (speed_i == SPD_SS) ? st.ss_det : st.hs_det;
            nxt_st.ms_cnt = 15'h0;
        end else if (st.detached) begin
            nxt_st.ms_cnt = ms_tick ? 15'h0 : st.ms_cnt + 15'h1;
            if (st.det_ms == 16'h0) begin
                nxt_st.detached = 1'b0;
            end else if (ms_tick) begin
                nxt_st.det_ms = st.det_ms - 16'h1;
            end
        end

        // Bulk-in transmitter; tokens during the delay are not served
        case (st.tx)
            TX_IDLE: begin
                if (in_token_i) begin
                    if (data_full_i && !(limit_on && st.byte_cnt >= limit_bytes)) begin
                        nxt_st.pkt_full = 1'b1;
                        nxt_st.byte_cnt = st.byte_cnt + mps;
                    end else begin
                        nxt_st.tx = TX_DELAY;
                        nxt_st.wait_ps = 32'h0;
                    end
                end
            end
            TX_DELAY: begin
                if (st.wait_ps >= 32'(st.delay) * DELAY_UNIT_PS) begin
                    nxt_st.pkt_short = 1'b1;
                    nxt_st.tx = TX_IDLE;
                    nxt_st.byte_cnt = 20'h0;
                end else begin
                    // Picoseconds, so the 16.667 ns unit needs no rounding
                    nxt_st.wait_ps = st.wait_ps + CLK_PS;
                end
            end
            default: begin
                nxt_st.tx = TX_IDLE;
            end
        endcase

        nxt_st.hs_scale_timing = nxt_st.scale[0];
        nxt_st.hs_scale_susp = nxt_st.scale[1];
        // SuperSpeed scaling, no TxEq overrides bit 4
        if (nxt_st.scale[1] || !nxt_st.txeq_en) begin
            nxt_st.txeq_cnt = 17'h0;
        end else if (nxt_st.scale[0]) begin
            nxt_st.txeq_cnt = TXEQ_SCALED;
        end else begin
            nxt_st.txeq_cnt = TXEQ_REAL;
        end
        nxt_st.lfps_ns = nxt_st.scale[0] ? LFPS_POLL_SCALED_NS : LFPS_POLL_REAL_NS;
        nxt_st.warm_us = nxt_st.scale[0] ? WARM_RX_SCALED_US : WARM_RX_REAL_US;
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st <= '0;
            st.scale <= SCALE_RST;
            st.txeq_en <= TXEQ_EN_RST;
            st.burst_en <= BURST_EN_RST;
            st.ss_det <= SS_DETACH_HW;
            st.hs_det <= HIGHSPEED_DETACH_MS_HW;
            st.img_ss <= SS_DETACH_HW;
            st.img_hs <= HIGHSPEED_DETACH_MS_HW;
            st.bulk_in_burst_limit <= BURST_RST;
            st.delay <= DELAY_RST;
            st.tx <= TX_IDLE;
            st.txeq_cnt <= TXEQ_REAL;
            st.lfps_ns <= LFPS_POLL_REAL_NS;
            st.warm_us <= WARM_RX_REAL_US;
        end else begin
            st <= nxt_st;
        end
    end

    assign rdata_o = st.rdata;
    assign detached_o = st.detached;
    assign pkt_full_o = st.pkt_full;
    assign pkt_short_o = st.pkt_short;
    assign txeq_count_o = st.txeq_cnt;
    assign lfps_poll_ns_o = st.lfps_ns;
    assign warm_rx_us_o = st.warm_us;
    assign hs_scale_timing_o = st.hs_scale_timing;
    assign hs_scale_susp_o = st.hs_scale_susp;

    // Checks sample registered outputs one edge after launch
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    a_scale_hs_flags: assert property (
        ##1 (hs_scale_timing_o == st.scale[0]) && (hs_scale_susp_o == st.scale[1]))
        else $error("HS scale flags disagree with scale field");

    a_scale_txeq_eight: assert property (
        (st.scale == 2'b01 && st.txeq_en) |-> (txeq_count_o == 17'h8 && warm_rx_us_o == 17'h1e))
        else $error("Scaled SuperSpeed timing wrong");

    a_scale_no_txeq: assert property (
        st.scale[1] |-> (txeq_count_o == 17'h0))
        else $error("TxEq sent while scale bit 1 set");

    a_restore_image: assert property (
        (usb_reset_i && !rst_protect_i && !img_load_i) |=> (st.ss_det == $past(st.img_ss)))
        else $error("Detach field not restored from image");

    a_protect_keep: assert property (
        (lite_reset_i && rst_protect_i && !wr_i && !img_load_i) |=> $stable(st.hs_det))
        else $error("Protected reset changed detach field");

    a_detach_start: assert property (
        (soft_reset_req_i && ((speed_i == SPD_SS) ? st.ss_det : st.hs_det) != 16'h0)
        |=> detached_o ##1 detached_o)
        else $error("Soft reset did not detach");

    a_burst_stop: assert property (
        (st.tx == TX_IDLE && in_token_i && limit_on && st.byte_cnt >= limit_bytes)
        |=> (!pkt_full_o && st.tx == TX_DELAY))
        else $error("Full packet past burst limit");

    a_limit_gate: assert property (
        (limit_bytes <= 20'h800 || !st.burst_en) |-> !limit_on)
        else $error("Burst limit active while disabled");

    a_short_delay: assert property (
        $rose(pkt_short_o) |-> ($past(st.wait_ps) >= 32'($past(st.delay)) * 32'h411b))
        else $error("Short packet sent before delay");

    a_counter_clear: assert property (
        pkt_short_o |-> (st.byte_cnt == 20'h0))
        else $error("Burst counter not cleared");

    a_read_zero: assert property (
        (rd_i && addr_i == OFS_BURST) |=> (rdata_o[31:8] == 24'h0))
        else $error("Reserved burst bits read nonzero");

    a_real_timing: assert property (
        (st.scale == 2'b00 && st.txeq_en) |-> (txeq_count_o == TXEQ_REAL && !hs_scale_timing_o))
        else $error("Real timing not used with scale zero");

    a_scale_lfps_short: assert property (
        (st.scale == 2'b01) |-> (lfps_poll_ns_o == LFPS_POLL_SCALED_NS))
        else $error("LFPS polling burst not shortened");

    a_img_eeprom: assert property (
        (img_load_i && eeprom_present_i)
        |=> (st.img_ss == $past(eeprom_ss_det_i) && st.img_hs == $past(eeprom_hs_det_i)))
        else $error("EEPROM image not loaded");

    a_img_otp: assert property (
        (img_load_i && !eeprom_present_i && otp_configured_i)
        |=> (st.img_ss == $past(otp_ss_det_i) && st.img_hs == $past(otp_hs_det_i)))
        else $error("OTP image not loaded");

    a_img_hard: assert property (
        (img_load_i && !eeprom_present_i && !otp_configured_i)
        |=> (st.img_ss == SS_DETACH_HW && st.img_hs == HIGHSPEED_DETACH_MS_HW))
        else $error("Hard defaults not loaded");

    a_restore_lite: assert property (
        (lite_reset_i && !rst_protect_i && !img_load_i) |=> (st.hs_det == $past(st.img_hs)))
        else $error("Lite reset did not restore detach field");

    a_detach_end: assert property (
        (st.detached && st.det_ms == 16'h0 && !soft_reset_req_i) |=> !detached_o)
        else $error("Detach outlasted its duration");

    a_detach_hold: assert property (
        (st.detached && st.det_ms != 16'h0 && !soft_reset_req_i) |=> detached_o)
        else $error("Detach ended early");

    a_detach_pick: assert property (
        (soft_reset_req_i && speed_i != SPD_SS) |=> (st.det_ms == $past(st.hs_det)))
        else $error("High/full-speed detach time not used");

    a_full_count: assert property (
        (st.tx == TX_IDLE && in_token_i && data_full_i && !limit_on && speed_i == SPD_HS)
        |=> (pkt_full_o && st.byte_cnt == $past(st.byte_cnt) + UNIT_HS))
        else $error("High-speed packet not counted as 512 bytes");

    a_limit_enable: assert property (
        (st.tx == TX_IDLE && in_token_i && data_full_i && !st.burst_en) |=> pkt_full_o)
        else $error("Burst limit acted while disabled");

    a_delay_hold: assert property (
        (st.tx == TX_DELAY && st.wait_ps < 32'(st.delay) * DELAY_UNIT_PS) |=> !pkt_short_o)
        else $error("Short packet sent during delay");

    a_short_pulse: assert property (
        pkt_short_o |=> !pkt_short_o)
        else $error("Short packet pulse too long");

    a_rdata_idle: assert property (
        !rd_i |=> (rdata_o == 32'h0))
        else $error("Read data stood past its cycle");

    a_cfg0_reserved: assert property (
        (rd_i && addr_i == OFS_CFG0) |=> (rdata_o[31:6] == 26'h0 && rdata_o[3:2] == 2'h0))
        else $error("Reserved config bits read nonzero");

endmodule : ubt_usb_bulk_in

// ---- testbench/ubt_host_model.sv ----
// Behavioural host controller polling the bulk-in endpoint
`timescale 1ns/100ps
module ubt_host_model (
    input wire logic clk_sys_i, // System clock
    input wire logic poll_en_i, // Poll while high
    input wire logic [3:0] gap_i, // Idle cycles between tokens
    input wire logic pkt_full_i, // Full packet seen
    input wire logic pkt_short_i, // Short packet seen
    output logic in_token_o, // Token pulse
    output logic [7:0] full_cnt_o, // Full packets taken
    output logic [7:0] short_cnt_o, // Short packets taken
    output logic [7:0] lat_o // Token to last answer, cycles
);
    int n;
    initial begin
        in_token_o = 1'b0;
        full_cnt_o = 8'h00;
        short_cnt_o = 8'h00;
        lat_o = 8'h00;
        forever begin
            @(posedge clk_sys_i);
            if (poll_en_i) begin
                in_token_o <= 1'b1;
                @(posedge clk_sys_i);
                in_token_o <= 1'b0;
                n = 0;
                // Bounded so a silent device cannot hang the host
                do begin
                    @(posedge clk_sys_i);
                    n++;
                end while (!pkt_full_i && !pkt_short_i && n < 200);
                lat_o <= n[7:0];
                full_cnt_o <= full_cnt_o + {7'h00, pkt_full_i};
                short_cnt_o <= short_cnt_o + {7'h00, pkt_short_i};
                // A short packet holds the host only while its pulse is high and polling is enabled
                while (pkt_short_i && poll_en_i) @(posedge clk_sys_i);
                repeat (gap_i) @(posedge clk_sys_i);
            end
        end
    end
endmodule : ubt_host_model

// ---- testbench/test_usb_bulk_in_timing_config.sv ----
// Self-checking bench for the bulk-in timing and configuration block
`timescale 1ns/100ps
module test_usb_bulk_in_timing_config;
    import ubt_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} ubt_row_s;
    typedef struct packed {logic [1:0] sp; logic [7:0] cap; logic en; logic df; logic [7:0] nf;} ubt_blk_s;
    localparam int MSC = 10;
    logic clk_sys_i, reset_i, usb_reset_i, lite_reset_i, rst_protect_i, img_load_i;
    logic eeprom_present_i, otp_configured_i, soft_reset_req_i, in_token_i, data_full_i;
    logic [15:0] eeprom_ss_det_i, eeprom_hs_det_i, otp_ss_det_i, otp_hs_det_i;
    logic [1:0] speed_i;
    logic [7:0] addr_i, fulls, shorts, lat, f0, s0;
    logic [31:0] wdata_i, rdata_o;
    logic wr_i, rd_i, detached_o, pkt_full_o, pkt_short_o, hs_scale_timing_o, hs_scale_susp_o;
    logic [16:0] txeq_count_o, lfps_poll_ns_o, warm_rx_us_o;
    logic poll_en;
    logic [3:0] gap;
    int miscompares = 0;
    int n_checks = 0;
    int n;
    ubt_row_s rows [5] = '{'{8'h88, 32'h12345678, 32'h12345678},
        '{8'h90, 32'hffffffff, 32'h000000ff}, '{8'h94, 32'hffffffff, 32'h0000ffff},
        '{8'h84, 32'hffffffff, 32'h00000000}, '{8'h80, 32'h00000033, 32'h00000033}};
    // Active limits first: a free-running burst leaves the byte count high
    ubt_blk_s blk [8] = '{'{SPD_HS, 8'h05, 1'b1, 1'b0, 8'h00},
        '{SPD_HS, 8'h05, 1'b1, 1'b1, 8'h05}, '{SPD_HS, 8'h05, 1'b1, 1'b1, 8'h05},
        '{SPD_SS, 8'h03, 1'b1, 1'b1, 8'h03}, '{SPD_FS, 8'h21, 1'b1, 1'b1, 8'h21},
        '{SPD_FS, 8'h20, 1'b1, 1'b1, 8'hff}, '{SPD_SS, 8'h02, 1'b1, 1'b1, 8'hff},
        '{SPD_HS, 8'h05, 1'b0, 1'b1, 8'hff}};
    ubt_usb_bulk_in #(.MS_CYC(MSC)) ubt_usb_bulk_in_inst (.clk_sys_i, .reset_i, .usb_reset_i,
        .lite_reset_i, .rst_protect_i, .img_load_i, .eeprom_present_i, .otp_configured_i,
        .eeprom_ss_det_i, .eeprom_hs_det_i, .otp_ss_det_i, .otp_hs_det_i, .soft_reset_req_i,
        .speed_i, .in_token_i, .data_full_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .detached_o, .pkt_full_o, .pkt_short_o, .txeq_count_o, .lfps_poll_ns_o,
        .warm_rx_us_o, .hs_scale_timing_o, .hs_scale_susp_o);
    ubt_host_model ubt_host_model_inst (.clk_sys_i(clk_sys_i), .poll_en_i(poll_en),
        .gap_i(gap), .pkt_full_i(pkt_full_o), .pkt_short_i(pkt_short_o),
        .in_token_o(in_token_i), .full_cnt_o(fulls), .short_cnt_o(shorts), .lat_o(lat));
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
        n_checks++;
        if ($isunknown(g) || g < lo || g > hi) begin
            miscompares++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= w;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        chk(nm, e, rdata_o);
    endtask : rchk
    // Pulse: 0 USB reset, 1 lite reset, 2 image load, 3 soft reset request
    task automatic pls(input int k);
        @(posedge clk_sys_i);
        usb_reset_i <= (k == 0);
        lite_reset_i <= (k == 1);
        img_load_i <= (k == 2);
        soft_reset_req_i <= (k == 3);
        @(posedge clk_sys_i);
        {usb_reset_i, lite_reset_i, img_load_i, soft_reset_req_i} <= 4'h0;
    endtask : pls
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        print_verdict();
    end
    initial begin
        {reset_i, usb_reset_i, lite_reset_i, rst_protect_i, img_load_i} = 5'h10;
        {eeprom_present_i, otp_configured_i, soft_reset_req_i, data_full_i} = 4'h0;
        {eeprom_ss_det_i, eeprom_hs_det_i} = 32'h00030002;
        {otp_ss_det_i, otp_hs_det_i} = 32'h00070005;
        {speed_i, addr_i, wdata_i, wr_i, rd_i, poll_en, gap} = '0;
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rchk("reg_row", rows[i].a, rows[i].e);
        end
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rchk("detach_rst", OFS_DETACH, {SS_DETACH_HW, HIGHSPEED_DETACH_MS_HW});
        rchk("burst_rst", OFS_BURST, 32'h00000000);
        rchk("delay_rst", OFS_DELAY, 32'h00000800);
        rchk("cfg0_rst", OFS_CFG0, 32'h00000010);
        speed_i <= SPD_SS;
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CFG0, 32'h10 | s);
            repeat (3) @(posedge clk_sys_i);
            chk("txeq", (s == 0) ? TXEQ_REAL : (s == 1) ? TXEQ_SCALED : 0, txeq_count_o);
            chk("lfps", s[0] ? LFPS_POLL_SCALED_NS : LFPS_POLL_REAL_NS, lfps_poll_ns_o);
            chk("warm", s[0] ? WARM_RX_SCALED_US : WARM_RX_REAL_US, warm_rx_us_o);
            chk("hs_flags", s, {hs_scale_susp_o, hs_scale_timing_o});
        end
        wr(OFS_CFG0, 32'h00000000);
        repeat (3) @(posedge clk_sys_i);
        chk("txeq_off", 0, txeq_count_o);
        {eeprom_present_i, otp_configured_i} <= 2'b11;
        pls(2);
        rchk("img_eeprom", OFS_DETACH, 32'h00030002);
        wr(OFS_DETACH, 32'h00440055);
        pls(0);
        rchk("usb_restore", OFS_DETACH, 32'h00030002);
        rst_protect_i <= 1'b1;
        wr(OFS_DETACH, 32'h00440055);
        pls(1);
        rchk("protected", OFS_DETACH, 32'h00440055);
        rst_protect_i <= 1'b0;
        pls(1);
        rchk("lite_restore", OFS_DETACH, 32'h00030002);
        eeprom_present_i <= 1'b0;
        pls(2);
        rchk("img_otp", OFS_DETACH, 32'h00070005);
        otp_configured_i <= 1'b0;
        pls(2);
        rchk("img_hw", OFS_DETACH, {SS_DETACH_HW, HIGHSPEED_DETACH_MS_HW});
        wr(OFS_DETACH, 32'h00030002);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys_i);
            speed_i <= 2'(k);
            pls(3);
            #1;
            n = 0;
            while (detached_o === 1'b1 && n < 1000) begin
                @(posedge clk_sys_i);
                #1;
                n++;
            end
            chk_rng("detach", (k == 2) ? 3 * MSC : 2 * MSC, (k == 2) ? 3 * MSC + 3 : 2 * MSC + 3, n);
        end
        wr(OFS_DELAY, 32'h0000000c);
        foreach (blk[i]) begin
            speed_i <= blk[i].sp;
            data_full_i <= blk[i].df;
            gap <= 4'(i % 3);
            wr(OFS_BURST, {24'h0, blk[i].cap});
            wr(OFS_CFG0, {26'h0, blk[i].en, 5'h0});
            f0 = fulls;
            s0 = shorts;
            poll_en <= 1'b1;
            n = 0;
            while (shorts == s0 && n < ((blk[i].nf == 8'hff) ? 150 : 400)) begin
                @(posedge clk_sys_i);
                n++;
            end
            poll_en <= 1'b0;
            repeat (20) @(posedge clk_sys_i);
            if (blk[i].nf == 8'hff) begin
                chk("no_short", s0, shorts);
                chk_rng("free_fulls", 20, 255, fulls - f0);
            end else begin
                chk("fulls", blk[i].nf, fulls - f0);
                chk_rng("short_delay", 5, 10, lat);
                rchk("status", OFS_STATUS, 32'h00400000);
            end
        end
        print_verdict();
    end
endmodule : test_usb_bulk_in_timing_config
